/* File: hw/vss_state_save.sv */
// Purpose: placement and gating of saved vector state
// Assumes: one access per request, results a cycle later
// Notes: address is relative to the save area base
`include "vss_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module vss_state_save (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              os_save_enable,
    input  wire logic [7:0]        feature_enable_mask,
    input  wire logic              mode64,
    input  wire logic              req_valid,
    input  wire vss_pkg::vss_op_type req_op,
    input  wire vss_pkg::vss_comp_type req_comp,
    input  wire logic [4:0]        req_elem,
    input  wire logic [7:0]        req_rfbm,
    input  wire logic              req_compacted,
    input  wire logic [7:0]        compaction_bitmap,
    input  wire logic [31:0]       restore_data,
    input  wire logic              query_valid,
    input  wire logic [31:0]       query_leaf,
    input  wire logic [31:0]       query_subleaf,
    output logic                   rsp_valid,
    output vss_pkg::vss_addr_type  rsp_addr,
    output logic [7:0]             rsp_size,
    output logic                   rsp_access,
    output logic                   rsp_fault,
    output logic [31:0]            rsp_save_data,
    output logic [31:0]            vec_fp_ctrl_status,
    output logic                   vec128_insn_ok,
    output logic                   vec256_insn_ok,
    output logic                   bound_insn_ok,
    output logic                   vec512_insn_ok,
    output logic                   query_done,
    output logic [31:0]            query_eax,
    output logic [31:0]            query_ebx,
    output logic [31:0]            query_ecx
);

    // ----------------------------------------
    // decode functions
    // ----------------------------------------

    // component enabled by os enable and mask
    function automatic logic comp_on(
        input logic [2:0] c,
        input logic       os,
        input logic [7:0] fem
    );
        case (c)
            3'h1:    comp_on = os & fem[1]; // see R6
            3'h2:    comp_on = os & fem[2]; // see R10
            3'h3,
            3'h4:    comp_on = os & (fem[4:3] == 2'h3); // see R13
            3'h5,
            3'h6,
            3'h7:    comp_on = os & (fem[7:5] == 3'h7); // see R18
            default: comp_on = 1'b0;
        endcase
    endfunction : comp_on

    // section size in bytes
    function automatic logic [15:0] sec_size(input logic [2:0] c);
        case (c)
            3'h2:    sec_size = `VSS_SZ_C2; // see R8
            3'h3:    sec_size = `VSS_SZ_C3; // see R11
            3'h4:    sec_size = `VSS_SZ_C4; // see R12
            3'h5:    sec_size = `VSS_SZ_C5; // see R14
            3'h6:    sec_size = `VSS_SZ_C6;
            3'h7:    sec_size = `VSS_SZ_C7;
            default: sec_size = 16'h0000;
        endcase
    endfunction : sec_size

    // round up to 64 when the section is aligned
    function automatic logic [15:0] align_up(
        input logic [15:0] p,
        input logic [2:0]  c
    );
        logic [7:0] am;
        am = `VSS_ALIGN_MASK;
        align_up = am[c] ? ((p + 16'h003f) & 16'hffc0) : p; // see R21
    endfunction : align_up

    // section start; standard map uses all present
    function automatic logic [15:0] sec_off(
        input logic [2:0] c,
        input logic [7:0] bm
    );
        logic [15:0] pos;
        pos = `VSS_EXT_BASE; // see R20
        for (int j = 2; j < 8; j++) begin
            if ((j[2:0] < c) && bm[j]) begin
                pos = align_up(pos, j[2:0]) + sec_size(j[2:0]);
            end
        end
        sec_off = align_up(pos, c); // see R21
    endfunction : sec_off

    // ----------------------------------------
    // element decode
    // ----------------------------------------

    logic        is_c1;     // legacy component
    logic        is_csr;    // control/status word
    logic        is_csrm;   // control/status mask
    logic        elem_ok;   // element in range
    logic        need64;    // needs 64-bit mode
    logic [15:0] e_off;     // offset in section
    logic [7:0]  e_size;    // element size
    logic [15:0] base_off;  // section offset
    logic        rfbm_sel;  // requested bit
    logic        acc_now;   // access allowed
    logic        flt_now;   // restore fault
    logic        is_rst;    // restore op

    assign is_c1   = (req_comp == 3'h1);
    assign is_csr  = is_c1 & (req_elem == 5'h10);
    assign is_csrm = is_c1 & (req_elem == 5'h11);
    assign is_rst  = (req_op == vss_pkg::VSS_OP_RESTORE);
    assign rfbm_sel = req_rfbm[req_comp];

    // element ranges per component
    assign elem_ok =
        is_c1              ? (req_elem <= 5'h11) :
        (req_comp == 3'h3) ? (req_elem < 5'h04) :
        (req_comp == 3'h4) ? (req_elem < 5'h02) :
        (req_comp == 3'h5) ? (req_elem < 5'h08) :
        (req_comp >= 3'h2) ? (req_elem < 5'h10) : 1'b0;

    // upper eight of a bank, or all high sixteen
    assign need64 =
        (req_comp == 3'h7) | // see R17
        ((is_c1 | (req_comp == 3'h2) | (req_comp == 3'h6))
         & (req_elem[4:3] == 2'h1)); // see R5 R9 R16

    // element size in bytes
    assign e_size =
        (is_csr | is_csrm)            ? 8'h04 :
        ((req_comp == 3'h4) |
         (req_comp == 3'h5))          ? 8'h08 :
        (req_comp == 3'h6)            ? 8'h20 :
        (req_comp == 3'h7)            ? 8'h40 : 8'h10;

    // element offset within its section
    assign e_off =
        is_csr  ? `VSS_CSR_OFF :  // see R1
        is_csrm ? `VSS_CSRM_OFF : // see R3
        is_c1   ? (`VSS_V128_OFF + {7'h00, req_elem, 4'h0}) : // see R4
        ({11'h000, req_elem} * {8'h00, e_size}); // see R9 R11 R15 R16 R17

    // legacy sits at zero; extended by format
    assign base_off =
        is_c1         ? 16'h0000 :
        req_compacted ? sec_off(req_comp, compaction_bitmap) :
                        sec_off(req_comp, `VSS_STD_MAP);

    // enabled, requested, in range, mode allows
    assign acc_now = req_valid & comp_on(req_comp, os_save_enable, feature_enable_mask)
                   & rfbm_sel & elem_ok & (mode64 | ~need64) // see R22 R5
                   & ~(is_csrm & is_rst); // see R3

    // reserved bits set by restored image
    assign flt_now = acc_now & is_rst & is_csr
                   & ((restore_data & ~`VSS_CSR_MASK) != 32'h0); // see R2

    // ----------------------------------------
    // instruction permission
    // ----------------------------------------

    // 128-bit use never depends on the save feature
    assign vec128_insn_ok = 1'b1; // see R7
    assign vec256_insn_ok = comp_on(3'h2, os_save_enable, feature_enable_mask); // see R10
    assign bound_insn_ok  = comp_on(3'h3, os_save_enable, feature_enable_mask); // see R13
    assign vec512_insn_ok = comp_on(3'h5, os_save_enable, feature_enable_mask); // see R18

    // ----------------------------------------
    // response registers
    // ----------------------------------------

    logic [31:0] csr_r;   // live control/status word
    logic [31:0] csr_nxt; // its next value

    // reload only on a clean restore
    assign csr_nxt = (acc_now & is_rst & is_csr & ~flt_now) ? restore_data : csr_r; // see R1

    // response and control/status state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid     <= 1'b0;
            rsp_addr      <= 16'h0000;
            rsp_size      <= 8'h00;
            rsp_access    <= 1'b0;
            rsp_fault     <= 1'b0;
            rsp_save_data <= 32'h0;
            csr_r         <= `VSS_CSR_RST;
        end else begin
            rsp_valid     <= req_valid;
            rsp_addr      <= base_off + e_off;
            rsp_size      <= e_size;
            rsp_access    <= acc_now;
            rsp_fault     <= flt_now;
            rsp_save_data <= is_csrm ? `VSS_CSR_MASK : csr_r; // see R3
            csr_r         <= csr_nxt;
        end
    end

    assign vec_fp_ctrl_status = csr_r;

    // ----------------------------------------
    // identification query
    // ----------------------------------------

    logic       q_hit; // leaf and sub-leaf known
    logic [2:0] q_c;   // component asked for
    logic [7:0] q_am;  // alignment flags

    assign q_c   = query_subleaf[2:0];
    assign q_am  = `VSS_ALIGN_MASK;
    assign q_hit = query_valid & (query_leaf == `VSS_QRY_LEAF)
                 & (query_subleaf[31:3] == 29'h0) & (q_c >= 3'h2);

    // size in first, offset in second result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            query_done <= 1'b0;
            query_eax  <= 32'h0;
            query_ebx  <= 32'h0;
            query_ecx  <= 32'h0;
        end else begin
            query_done <= query_valid;
            query_eax  <= q_hit ? {16'h0, sec_size(q_c)} : 32'h0; // see R19
            query_ebx  <= q_hit ? {16'h0, sec_off(q_c, `VSS_STD_MAP)} : 32'h0; // see R19
            query_ecx  <= q_hit ? {30'h0, q_am[q_c], 1'b0} : 32'h0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_csr_place;
        req_valid && is_csr |=> rsp_addr == 16'h0018;
    endproperty
    a_csr_place: assert property (p_csr_place) else $error("csr offset wrong"); // see R1

    property p_csr_load;
        acc_now && is_rst && is_csr && !flt_now |=> csr_r == $past(restore_data);
    endproperty
    a_csr_load: assert property (p_csr_load) else $error("csr not reloaded"); // see R1

    property p_fault;
        flt_now |=> rsp_fault && $stable(csr_r);
    endproperty
    a_fault: assert property (p_fault) else $error("fault missed or csr changed"); // see R2

    property p_mask_ign;
        req_valid && is_csrm && is_rst |=> !rsp_access && rsp_addr == 16'h001c;
    endproperty
    a_mask_ign: assert property (p_mask_ign) else $error("mask field used on restore"); // see R3

    property p_v128_lo;
        req_valid && is_c1 && req_elem < 5'h08 |=> rsp_addr == 16'h00a0 + {7'h00, $past(req_elem), 4'h0};
    endproperty
    a_v128_lo: assert property (p_v128_lo) else $error("128-bit reg offset wrong"); // see R4

    property p_mode64;
        req_valid && !mode64 && need64 |=> !rsp_access;
    endproperty
    a_mode64: assert property (p_mode64) else $error("upper regs touched outside 64-bit"); // see R5

    property p_v128_gate;
        rsp_access && $past(is_c1) |-> $past(os_save_enable) && $past(feature_enable_mask[1]);
    endproperty
    a_v128_gate: assert property (p_v128_gate) else $error("128-bit state not enabled"); // see R6

    property p_top16;
        req_valid && req_comp == 3'h7 && !mode64 ##1 1'b1 |-> !rsp_access;
    endproperty
    a_top16: assert property (p_top16) else $error("high sixteen outside 64-bit"); // see R17

    property p_ext_gate;
        rsp_access && $past(req_comp) >= 3'h5 |-> $past(vec512_insn_ok);
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("512-bit state not enabled"); // see R18

    property p_query;
        q_hit && q_c == 3'h2 |=> query_done && query_eax == 32'h100 && query_ebx == 32'h240;
    endproperty
    a_query: assert property (p_query) else $error("query answer wrong"); // see R19

    property p_rfbm;
        rsp_access |-> $past(rfbm_sel);
    endproperty
    a_rfbm: assert property (p_rfbm) else $error("section not requested"); // see R22

    c_fault:   cover property (flt_now ##1 rsp_fault);
    c_v256_hi: cover property (acc_now && req_comp == 3'h2 && need64);
    c_compact: cover property (acc_now && req_compacted && req_comp == 3'h6);
    c_query:   cover property (q_hit ##1 query_done);

endmodule : vss_state_save
`default_nettype wire

/* File: hw/vss_defs.svh */
// Purpose: constants of the vector state save layout
// Assumes: byte offsets relative to the save area base
// Notes: included by its bare name
// Function
// (R1) control/status word at legacy bytes 27:24
// (R2) restore faults on reserved control/status bits
// (R3) mask stored at 31:28, ignored on restore
// (R4) 128-bit regs 0-7 at bytes 287:160
// (R5) 128-bit regs 8-15 only in 64-bit mode
// (R6) 128-bit state needs os enable, bit 1
// (R7) 128-bit instructions always usable
// (R8) 256-bit upper halves are component 2
// (R9) upper half i at 16i; 8-15 need 64-bit
// (R10) 256-bit use needs os enable, bit 2
// (R11) four bound regs, 16 bytes each
// (R12) bound config at 7:0, status 15:8
// (R13) bound use needs os enable, bits 4:3
// (R14) 512-bit state is components 5 to 7
// (R15) opmask i at bytes 8i+7:8i
// (R16) 512-bit half i at 32i; 8-15 need 64-bit
// (R17) high sixteen regs only in 64-bit mode
// (R18) 512-bit use needs os enable, bits 7:5
// (R19) query returns section offset and size
// (R20) extended region starts at byte 576
// (R21) compacted aligned sections round to 64
// (R22) touch only enabled and requested sections
`ifndef VSS_DEFS_SVH
`define VSS_DEFS_SVH
// ----------------------------------------
// legacy region
// ----------------------------------------
`define VSS_CSR_OFF    16'h0018
`define VSS_CSRM_OFF   16'h001c
`define VSS_V128_OFF   16'h00a0
`define VSS_CSR_MASK   32'h0000ffff
`define VSS_CSR_RST    32'h00001f80
// ----------------------------------------
// extended region
// ----------------------------------------
`define VSS_EXT_BASE   16'h0240
`define VSS_SZ_C2      16'h0100
`define VSS_SZ_C3      16'h0040
`define VSS_SZ_C4      16'h0010
`define VSS_SZ_C5      16'h0040
`define VSS_SZ_C6      16'h0200
`define VSS_SZ_C7      16'h0400
`define VSS_ALIGN_MASK 8'h00
`define VSS_STD_MAP    8'hfc
`define VSS_QRY_LEAF   32'h0000000d
`endif

/* File: hw/vss_pkg.sv */
// Purpose: types of the vector state save layout
// Assumes: constants live in vss_defs.svh
// Notes: nothing is imported by users
package vss_pkg;
    // save or restore access
    typedef enum logic {
        VSS_OP_SAVE,
        VSS_OP_RESTORE
    } vss_op_type;
    // state component number
    typedef logic [2:0]  vss_comp_type;
    // byte offset in the save area
    typedef logic [15:0] vss_addr_type;
endpackage : vss_pkg

/* File: bench/vss_mem_model.sv */
// Purpose: save area memory as seen by vss_state_save
// Assumes: a save response lands one cycle after its request
// Notes: only the two legacy control words are kept
`timescale 1ns/1ns
`default_nettype none
module vss_mem_model (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  req_valid,
    input  wire vss_pkg::vss_op_type   req_op,
    input  wire logic                  rsp_valid,
    input  wire vss_pkg::vss_addr_type rsp_addr,
    input  wire logic                  rsp_access,
    input  wire logic [31:0]           rsp_save_data,
    input  wire vss_pkg::vss_addr_type rd_addr,
    output logic [31:0]                rd_word
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic        save_r;      // request one cycle back was a save
    logic [31:0] csr_slot_r;  // bytes 27:24 of the area
    logic [31:0] mask_slot_r; // bytes 31:28 of the area
    // unwritten slots hold junk with reserved bits set, so a stale restore faults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            save_r      <= 1'b0;
            csr_slot_r  <= 32'h5a5a5a5a;
            mask_slot_r <= 32'ha5a5a5a5;
        end else begin
            save_r <= req_valid && (req_op == vss_pkg::VSS_OP_SAVE);
            if (rsp_valid && rsp_access && save_r && rsp_addr == 16'h0018) begin
                csr_slot_r <= rsp_save_data;
            end
            if (rsp_valid && rsp_access && save_r && rsp_addr == 16'h001c) begin
                mask_slot_r <= rsp_save_data;
            end
        end
    end
    // read port for the bench, other bytes give a changing-free junk word
    assign rd_word = (rd_addr == 16'h0018) ? csr_slot_r :
                     (rd_addr == 16'h001c) ? mask_slot_r : 32'h3c3c3c3c;
endmodule : vss_mem_model
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: self-checking bench for vss_state_save
// Assumes: response and query answer one cycle after the request
// Notes: integer model below predicts every response
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0, rst = 1'b1, os_save_enable = 1'b0, mode64 = 1'b0;
    logic req_valid = 1'b0, req_compacted = 1'b0, query_valid = 1'b0;
    logic [7:0] feature_enable_mask = 8'h00, req_rfbm = 8'h00, compaction_bitmap = 8'h00;
    vss_pkg::vss_op_type req_op = vss_pkg::VSS_OP_SAVE;
    vss_pkg::vss_comp_type req_comp = 3'h0;
    logic [4:0] req_elem = 5'h00;
    logic [31:0] restore_data = 32'h0, query_leaf = 32'h0, query_subleaf = 32'h0;
    logic rsp_valid, rsp_access, rsp_fault, query_done, ok128, ok256, okbnd, ok512;
    vss_pkg::vss_addr_type rsp_addr;
    vss_pkg::vss_addr_type rd_addr = 16'h0018;
    logic [7:0] rsp_size;
    logic [31:0] rsp_save_data, vec_fp_ctrl_status, query_eax, query_ebx, query_ecx, rd_word;
    // ----------------------------------------
    // model state
    // ----------------------------------------
    int sz_t[8] = '{0, 0, 256, 64, 16, 64, 512, 1024};   // section sizes
    int off_t[8] = '{0, 0, 576, 832, 896, 912, 976, 1488}; // standard offsets
    int es_t[8] = '{0, 16, 16, 16, 8, 8, 32, 64};           // element sizes
    int n_t[8] = '{0, 18, 16, 4, 2, 8, 16, 16};             // element counts
    int bad_count = 0, check_count = 0, i, e_addr, e_size, e_ax, e_bx;
    integer seed = 32'h023e;
    logic e_v = 1'b0, e_q = 1'b0, e_acc, e_f, e_sdv, g_os, g_m64, g_cmp;
    logic [31:0] e_sd, csr_m = 32'h00001f80, r;
    logic [7:0] g_fem, g_rfbm, g_bm;
    always #50 clk = ~clk;
    vss_state_save dut (.clk(clk), .rst(rst), .os_save_enable(os_save_enable),
        .feature_enable_mask(feature_enable_mask), .mode64(mode64), .req_valid(req_valid),
        .req_op(req_op), .req_comp(req_comp), .req_elem(req_elem), .req_rfbm(req_rfbm),
        .req_compacted(req_compacted), .compaction_bitmap(compaction_bitmap),
        .restore_data(restore_data), .query_valid(query_valid), .query_leaf(query_leaf),
        .query_subleaf(query_subleaf), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr),
        .rsp_size(rsp_size), .rsp_access(rsp_access), .rsp_fault(rsp_fault),
        .rsp_save_data(rsp_save_data), .vec_fp_ctrl_status(vec_fp_ctrl_status),
        .vec128_insn_ok(ok128), .vec256_insn_ok(ok256), .bound_insn_ok(okbnd),
        .vec512_insn_ok(ok512), .query_done(query_done), .query_eax(query_eax),
        .query_ebx(query_ebx), .query_ecx(query_ecx));
    vss_mem_model mem (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_access(rsp_access),
        .rsp_save_data(rsp_save_data), .rd_addr(rd_addr), .rd_word(rd_word));
    // ----------------------------------------
    // compare, verdict
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // one cycle: drive at the edge, check the previous request, predict this one
    task automatic step(input logic v, input vss_pkg::vss_op_type op, input int c, input int e,
                        input logic [31:0] d, input logic qv, input logic [31:0] lf, input int sb);
        int b;
        logic hi, en, rs;
        @(posedge clk);
        os_save_enable <= g_os;
        feature_enable_mask <= g_fem;
        mode64 <= g_m64;
        req_rfbm <= g_rfbm;
        req_compacted <= g_cmp;
        compaction_bitmap <= g_bm;
        req_valid <= v;
        req_op <= op;
        req_comp <= 3'(c);
        req_elem <= 5'(e);
        restore_data <= d;
        query_valid <= qv;
        query_leaf <= lf;
        query_subleaf <= 32'(sb);
        @(negedge clk);
        chk(32'(rsp_valid), 32'(e_v));
        if (e_v) begin
            chk(32'(rsp_access), 32'(e_acc));
            chk(32'(rsp_fault), 32'(e_f));
            if (e_acc) chk(32'(rsp_addr), e_addr);
            if (e_acc) chk(32'(rsp_size), e_size);
            if (e_sdv) chk(rsp_save_data, e_sd);
        end
        chk(vec_fp_ctrl_status, csr_m);
        chk(32'(query_done), 32'(e_q));
        if (e_q) chk(query_eax, e_ax);
        if (e_q) chk(query_ecx, 32'h00000000);
        if (e_q) chk(query_ebx, e_bx);
        chk(32'({ok128, ok256, okbnd, ok512}), 32'({1'b1, g_os & g_fem[2], g_os & (&g_fem[4:3]),
            g_os & (&g_fem[7:5])}));
        b = off_t[c];
        if (g_cmp && c > 1) begin
            b = 576;
            for (int j = 2; j < c; j++) if (g_bm[j]) b += sz_t[j];
        end
        e_addr = (c == 1) ? ((e > 15) ? 24 + 4 * (e - 16) : 160 + 16 * e) : b + es_t[c] * e;
        e_size = (c == 1 && e > 15) ? 4 : es_t[c];
        hi = (c == 7) || ((c == 1 || c == 2 || c == 6) && e > 7 && e < 16);
        en = (c == 1) ? g_fem[1] : (c == 2) ? g_fem[2] : (c < 5) ? &g_fem[4:3] : &g_fem[7:5];
        e_acc = v && g_os && en && g_rfbm[c] && e < n_t[c] && !(hi && !g_m64) &&
                !(op == vss_pkg::VSS_OP_RESTORE && c == 1 && e == 17);
        rs = e_acc && op == vss_pkg::VSS_OP_RESTORE && c == 1 && e == 16;
        e_f = rs && d[31:16] != 16'h0;
        e_sdv = e_acc && op == vss_pkg::VSS_OP_SAVE && c == 1 && e > 15;
        e_sd = (e == 17) ? 32'h0000ffff : csr_m;
        if (rs && !e_f) csr_m = d;
        e_v = v;
        e_q = qv;
        hi = lf == 32'h0000000d && sb >= 2 && sb <= 7;
        e_ax = hi ? sz_t[sb] : 0;
        e_bx = hi ? off_t[sb] : 0;
    endtask : step
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {g_os, g_m64, g_cmp, g_fem, g_rfbm, g_bm} = {3'b101, 8'hff, 8'hff, 8'h00};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        step(0, vss_pkg::VSS_OP_SAVE, 0, 0, 0, 0, 0, 0);
        // clean load, reserved-bit load, ignored mask load, then save both words
        step(1, vss_pkg::VSS_OP_RESTORE, 1, 16, 32'h0000abcd, 0, 0, 0);
        step(1, vss_pkg::VSS_OP_RESTORE, 1, 16, 32'h0001abcd, 0, 0, 0);
        step(1, vss_pkg::VSS_OP_RESTORE, 1, 17, 32'h00000000, 0, 0, 0);
        step(1, vss_pkg::VSS_OP_SAVE, 1, 16, 0, 0, 0, 0);
        step(1, vss_pkg::VSS_OP_SAVE, 1, 17, 0, 0, 0, 0);
        repeat (2) step(0, vss_pkg::VSS_OP_SAVE, 0, 0, 0, 0, 0, 0);
        rd_addr = 16'h001c;
        #1 chk(rd_word, 32'h0000ffff);
        rd_addr = 16'h0018;
        #1 chk(rd_word, csr_m);
        step(1, vss_pkg::VSS_OP_RESTORE, 1, 16, rd_word, 0, 0, 0);
        // random traffic over every component, both modes and random enable patterns
        for (i = 0; i < 900; i++) begin
            g_os = ($random(seed) & 7) != 0;
            g_fem = 8'($random(seed) | $random(seed));
            g_rfbm = 8'($random(seed) | $random(seed));
            g_m64 = $random(seed) & 1;
            g_cmp = $random(seed) & 1;
            g_bm = 8'($random(seed));
            r = $random(seed);
            step(r[1:0] != 2'b00, vss_pkg::vss_op_type'(r[2]), int'(r[5:3]), int'(r[10:6]) % 20,
                 r[11] ? 32'($random(seed)) & 32'h0000ffff : 32'($random(seed)), r[12],
                 r[14:13] != 2'b00 ? 32'h0000000d : 32'($random(seed)), int'(r[19:16]) % 9);
        end
        repeat (2) step(0, vss_pkg::VSS_OP_SAVE, 0, 0, 0, 0, 0, 0);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
